// ===== rtl/shd_pkg.sv
// Shared constants for the half-step stepper drive
package shd_pkg;
	// Register word addresses on the plain register port
	localparam logic [3:0] ADDR_MODE     = 4'h0;
	localparam logic [3:0] ADDR_CONTROL  = 4'h1;
	localparam logic [3:0] ADDR_IRQ_EN   = 4'h2;
	localparam logic [3:0] ADDR_FLAGS    = 4'h3;
	localparam logic [3:0] ADDR_IO_SETUP = 4'h4;
	localparam logic [3:0] ADDR_COUNT    = 4'h5;
	localparam logic [3:0] ADDR_COMPARE  = 4'h6;
	localparam logic [3:0] ADDR_PORT_DAT = 4'h7;
	localparam logic [3:0] ADDR_PORT_DIR = 4'h8;
	localparam logic [3:0] ADDR_MOTION   = 4'h9;
	localparam logic [3:0] ADDR_ACCEL_N  = 4'ha;
	localparam logic [3:0] ADDR_CONST_N  = 4'hb;
	localparam logic [3:0] ADDR_DECEL_N  = 4'hc;
	localparam logic [3:0] ADDR_HOLD_N   = 4'hd;
	localparam logic [3:0] ADDR_STATUS   = 4'he;
	// Field positions
	localparam int START_BIT   = 7;
	localparam int CLEAR_BIT   = 7;
	localparam int CKS_LSB     = 4;
	localparam int MATCH_BIT   = 0;
	localparam int MOTION_BIT  = 0;
	// Clock select codes
	localparam logic [2:0] CKS_DIV1 = 3'h0;
	localparam logic [2:0] CKS_DIV2 = 3'h1;
	localparam logic [2:0] CKS_DIV4 = 3'h2;
	localparam logic [2:0] CKS_DIV8 = 3'h3;
	// Reset values
	localparam logic [15:0] COMPARE_RST = 16'hffff;
	localparam logic [7:0]  PORT_RST    = 8'h00;
	localparam logic [15:0] ACCEL_RST   = 16'h0060;
	localparam logic [15:0] CONST_RST   = 16'h0060;
	localparam logic [15:0] DECEL_RST   = 16'h0060;
	localparam logic [15:0] HOLD_RST    = 16'h0010;
	// Phase bits on the port: A, B, not A, not B
	localparam int PH_A    = 3;
	localparam int PH_B    = 2;
	localparam int PH_ABAR = 1;
	localparam int PH_BBAR = 0;
	localparam int PRESCALE_W = 13;
	localparam int RAMP_LEN   = 96;
	// Motion modes
	typedef enum logic [1:0] {MODE_ACCEL, MODE_CONST, MODE_DECEL, MODE_HOLD} shd_mode_t;
endpackage : shd_pkg

// ===== rtl/shd_ramp_rom.sv
// Step period ramp table for acceleration and deceleration
`timescale 1ns/1ps
module shd_ramp_rom #(
	parameter int DEPTH = 96
) (
	input  wire logic [6:0]  index,
	output logic      [15:0] period
);
	logic [15:0] table_mem [0:DEPTH-1];

	// Refuse a depth that the fixed contents cannot fill
	if (DEPTH != 96)
	begin : g_depth_check
		$error("ramp table holds exactly 96 entries");
	end

	// Constant ramp periods, longest first
	always_comb
	begin
		table_mem = '{
			16'hffff, 16'hf000, 16'he000, 16'hd500, 16'hce40, 16'hc738, 16'hc030, 16'hb928,
			16'hb220, 16'hab18, 16'ha410, 16'h9dd0, 16'h9790, 16'h9150, 16'h8ca0, 16'h87f0,
			16'h8340, 16'h8020, 16'h7d00, 16'h7aa8, 16'h7850, 16'h75f8, 16'h74bd, 16'h7148,
			16'h6fb8, 16'h6e28, 16'h6c98, 16'h6b08, 16'h6978, 16'h67e8, 16'h66bc, 16'h6590,
			16'h6464, 16'h6338, 16'h620c, 16'h6144, 16'h607c, 16'h5fb4, 16'h5eec, 16'h5dca,
			16'h5ca8, 16'h5b86, 16'h5a64, 16'h5942, 16'h5820, 16'h56fe, 16'h55dc, 16'h54ba,
			16'h5398, 16'h5276, 16'h5154, 16'h5032, 16'h4f10, 16'h4dee, 16'h4ccc, 16'h4baa,
			16'h4a88, 16'h4966, 16'h4844, 16'h4722, 16'h4600, 16'h44de, 16'h43bc, 16'h429a,
			16'h4178, 16'h4056, 16'h3f34, 16'h3e12, 16'h3cf0, 16'h3bc4, 16'h3a34, 16'h3890,
			16'h373c, 16'h35e8, 16'h3494, 16'h33d6, 16'h3318, 16'h325a, 16'h319c, 16'h30de,
			16'h3064, 16'h2fea, 16'h2f70, 16'h2ef6, 16'h2e7c, 16'h2e02, 16'h2d9c, 16'h2d36,
			16'h2cd0, 16'h2c6a, 16'h2c04, 16'h2b9e, 16'h2b38, 16'h2ad2, 16'h2a6c, 16'h2a00
		};
		period = (index < 7'(DEPTH)) ? table_mem[index] : table_mem[DEPTH-1];
	end
endmodule : shd_ramp_rom

// ===== rtl/shd_stepper_half_step_drive.sv
// Half-step stepper drive: prescaler, compare timer, phase port and motion sequencer
//
// Notes on behaviour
// - Forward walks A, A+B, B, B+nA, nA, nA+nB, nB, nB+A, repeating.
// - Reverse walks the same eight patterns in opposite order.
// - A high phase bit excites that phase; low leaves it off.
// - Stop holds the last step's pattern for a configured number of periods.
// - Cycle forward, stop, reverse, stop repeats without end.
// - Acceleration shortens the period each step for a configured step count.
// - Constant speed issues a configured step count at a fixed period.
// - Deceleration lengthens the period for a configured count, then stop hold.
// - A 13-bit prescaler increments every clock and feeds divided ticks.
// - 16-bit readable writable up-counter on clock, /2, /4, /8 or external.
// - Compare value is checked against the counter on each count tick while started; equality sets the match flag.
// - Match flag with its enable bit raises the interrupt request.
// - Control register picks the counter clock and clear on match.
// - Start bit lets the counter advance; cleared, it holds still.
// - Each compare match with motion enabled advances the excitation pattern by one step, except in hold.
// - Direction bits make phase bits outputs; port data drives them.
// - Interrupt enable register gates each timer request individually.
// - Bit 3 is A, bit 2 B, bit 1 not A, bit 0 not B.
// - Clear bit set zeroes the counter on match; otherwise it runs on.
// - Ramp phases load a new period from a 96-entry table each match.
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/1ps
module shd_stepper_half_step_drive #(
	parameter int RAMP_DEPTH = shd_pkg::RAMP_LEN
) (
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output logic      [15:0] reg_rdata,
	input  wire logic        ext_clock_in,
	output logic             phase_a_out,
	output logic             phase_b_out,
	output logic             phase_a_bar_out,
	output logic             phase_b_bar_out,
	output logic      [3:0]  phase_oe,
	output logic             timer_irq
);
	import shd_pkg::*;

	// Refuse a depth that the seven-bit ramp index cannot reach
	if (RAMP_DEPTH < 2 || RAMP_DEPTH > 127)
	begin : g_depth_check
		$error("ramp depth must lie between 2 and 127");
	end

	// Pattern lookup, forward order from index 0
	function automatic logic [3:0] pattern_of(input logic [2:0] idx);
		case (idx)
			3'h0: pattern_of = 4'h8;
			3'h1: pattern_of = 4'hc;
			3'h2: pattern_of = 4'h4;
			3'h3: pattern_of = 4'h6;
			3'h4: pattern_of = 4'h2;
			3'h5: pattern_of = 4'h3;
			3'h6: pattern_of = 4'h1;
			default: pattern_of = 4'h9;
		endcase
	endfunction : pattern_of

	logic [PRESCALE_W-1:0] prescale_r;
	logic [7:0]  mode_reg_r;
	logic [7:0]  control_r;
	logic [7:0]  irq_en_r;
	logic [7:0]  io_setup_r;
	logic        match_flag_r;
	logic [15:0] count_r;
	logic [15:0] compare_r;
	logic [7:0]  port_data_r;
	logic [7:0]  port_dir_r;
	logic        motion_en_r;
	logic [15:0] accel_n_r;
	logic [15:0] const_n_r;
	logic [15:0] decel_n_r;
	logic [15:0] hold_n_r;
	shd_mode_t   mode_r;
	logic        reverse_r;
	logic [2:0]  pat_idx_r;
	logic [6:0]  ramp_idx_r;
	logic [15:0] step_cnt_r;
	logic [2:0]  ext_sync_r;
	logic        ext_level_r;
	logic        ext_tick;
	logic        count_tick;
	logic        match;
	logic        wr_flags;
	logic        phase_done;
	logic [2:0]  pat_idx_nxt;
	logic [15:0] ramp_period;
	logic [6:0]  ramp_last;

	assign ramp_last = 7'(RAMP_DEPTH - 1);
	assign wr_flags  = reg_write && reg_addr == ADDR_FLAGS;

	shd_ramp_rom #(
		.DEPTH  (RAMP_DEPTH)
	) u_ramp (
		.index  (ramp_idx_r),
		.period (ramp_period)
	);

	// Free-running prescaler
	always_ff @(posedge clock)
	begin
		if (reset)
			prescale_r <= '0;
		else
			prescale_r <= prescale_r + 1'b1;
	end

	// External count clock: three stages, change accepted once stages two and three agree
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			ext_sync_r  <= 3'h0;
			ext_level_r <= 1'b0;
		end
		else
		begin
			ext_sync_r <= {ext_sync_r[1:0], ext_clock_in};
			if (ext_sync_r[1] == ext_sync_r[2])
				ext_level_r <= ext_sync_r[2];
		end
	end
	assign ext_tick = ext_sync_r[1] && ext_sync_r[2] && !ext_level_r;

	// Counter input select
	always_comb
	begin
		case (control_r[CKS_LSB+2:CKS_LSB])
			CKS_DIV1: count_tick = 1'b1;
			CKS_DIV2: count_tick = prescale_r[0];
			CKS_DIV4: count_tick = &prescale_r[1:0];
			CKS_DIV8: count_tick = &prescale_r[2:0];
			default:  count_tick = ext_tick;
		endcase
	end

	// Compare match fires when the counter ticks at equality
	assign match = mode_reg_r[START_BIT] && count_tick && (count_r == compare_r);

	// Timer counter: software write wins, then clear or increment
	always_ff @(posedge clock)
	begin
		if (reset)
			count_r <= '0;
		else if (reg_write && reg_addr == ADDR_COUNT)
			count_r <= reg_wdata;
		else if (match && control_r[CLEAR_BIT])
			count_r <= '0;
		else if (mode_reg_r[START_BIT] && count_tick)
			count_r <= count_r + 1'b1;
	end

	// Match flag: set wins over a software clear by writing zero
	always_ff @(posedge clock)
	begin
		if (reset)
			match_flag_r <= 1'b0;
		else if (match)
			match_flag_r <= 1'b1;
		else if (wr_flags && !reg_wdata[MATCH_BIT])
			match_flag_r <= 1'b0;
	end

	// Interrupt request gated by its enable
	always_ff @(posedge clock)
	begin
		if (reset)
			timer_irq <= 1'b0;
		else
			timer_irq <= match_flag_r && irq_en_r[MATCH_BIT];
	end

	// Plain software registers
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			mode_reg_r  <= 8'h00;
			control_r   <= 8'h00;
			irq_en_r    <= 8'h00;
			io_setup_r  <= 8'h00;
			port_dir_r  <= PORT_RST;
			motion_en_r <= 1'b0;
			accel_n_r   <= ACCEL_RST;
			const_n_r   <= CONST_RST;
			decel_n_r   <= DECEL_RST;
			hold_n_r    <= HOLD_RST;
		end
		else if (reg_write)
		begin
			case (reg_addr)
				ADDR_MODE:     mode_reg_r  <= reg_wdata[7:0];
				ADDR_CONTROL:  control_r   <= reg_wdata[7:0];
				ADDR_IRQ_EN:   irq_en_r    <= reg_wdata[7:0];
				ADDR_IO_SETUP: io_setup_r  <= reg_wdata[7:0];
				ADDR_PORT_DIR: port_dir_r  <= reg_wdata[7:0];
				ADDR_MOTION:   motion_en_r <= reg_wdata[MOTION_BIT];
				ADDR_ACCEL_N:  accel_n_r   <= reg_wdata;
				ADDR_CONST_N:  const_n_r   <= reg_wdata;
				ADDR_DECEL_N:  decel_n_r   <= reg_wdata;
				ADDR_HOLD_N:   hold_n_r    <= reg_wdata;
				default:       ;
			endcase
		end
	end

	// Last step of the current mode reached on this match
	assign phase_done = (step_cnt_r + 16'h0001) >= (mode_r == MODE_ACCEL ? accel_n_r :
		mode_r == MODE_CONST ? const_n_r : mode_r == MODE_DECEL ? decel_n_r : hold_n_r);

	// Pattern index steps modulo eight by direction, frozen in hold
	always_comb
	begin
		if (mode_r == MODE_HOLD)
			pat_idx_nxt = pat_idx_r;
		else if (reverse_r)
			pat_idx_nxt = pat_idx_r - 3'h1;
		else
			pat_idx_nxt = pat_idx_r + 3'h1;
	end

	// Motion sequencer on each compare match
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			mode_r     <= MODE_ACCEL;
			reverse_r  <= 1'b0;
			pat_idx_r  <= 3'h0;
			ramp_idx_r <= 7'h00;
			step_cnt_r <= 16'h0000;
		end
		else if (!motion_en_r)
		begin
			mode_r     <= MODE_ACCEL;
			ramp_idx_r <= 7'h00;
			step_cnt_r <= 16'h0000;
		end
		else if (match)
		begin
			pat_idx_r <= pat_idx_nxt;
			if (phase_done)
			begin
				step_cnt_r <= 16'h0000;
				case (mode_r)
					MODE_ACCEL: mode_r <= MODE_CONST;
					MODE_CONST: mode_r <= MODE_DECEL;
					MODE_DECEL: mode_r <= MODE_HOLD;
					default:
					begin
						mode_r     <= MODE_ACCEL;
						reverse_r  <= !reverse_r;
						ramp_idx_r <= 7'h00;
					end
				endcase
			end
			else
				step_cnt_r <= step_cnt_r + 16'h0001;
			// Ramp index walks up while accelerating, down while decelerating
			if (mode_r == MODE_ACCEL && ramp_idx_r < ramp_last)
				ramp_idx_r <= ramp_idx_r + 7'h01;
			else if (mode_r == MODE_DECEL && ramp_idx_r != 7'h00)
				ramp_idx_r <= ramp_idx_r - 7'h01;
		end
	end

	// Compare value: software write, or ramp reload on match
	always_ff @(posedge clock)
	begin
		if (reset)
			compare_r <= COMPARE_RST;
		else if (reg_write && reg_addr == ADDR_COMPARE)
			compare_r <= reg_wdata;
		else if (motion_en_r && match && (mode_r == MODE_ACCEL || mode_r == MODE_DECEL))
			compare_r <= ramp_period;
		// Constant speed and hold keep the last period
	end

	// Port data: software write, or the sequencer's next pattern
	always_ff @(posedge clock)
	begin
		if (reset)
			port_data_r <= PORT_RST;
		else if (reg_write && reg_addr == ADDR_PORT_DAT)
			port_data_r <= reg_wdata[7:0];
		else if (motion_en_r && match)
			port_data_r <= {port_data_r[7:4], pattern_of(pat_idx_nxt)};
	end

	// Phase pins: driven only where direction marks an output
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			phase_a_out     <= 1'b0;
			phase_b_out     <= 1'b0;
			phase_a_bar_out <= 1'b0;
			phase_b_bar_out <= 1'b0;
			phase_oe        <= 4'h0;
		end
		else
		begin
			phase_a_out     <= port_data_r[PH_A] && port_dir_r[PH_A];
			phase_b_out     <= port_data_r[PH_B] && port_dir_r[PH_B];
			phase_a_bar_out <= port_data_r[PH_ABAR] && port_dir_r[PH_ABAR];
			phase_b_bar_out <= port_data_r[PH_BBAR] && port_dir_r[PH_BBAR];
			phase_oe        <= port_dir_r[3:0];
		end
	end

	// Read data one cycle after the read strobe, zero otherwise
	always_ff @(posedge clock)
	begin
		if (reset || !reg_read)
			reg_rdata <= 16'h0000;
		else
		begin
			case (reg_addr)
				ADDR_MODE:     reg_rdata <= {8'h00, mode_reg_r};
				ADDR_CONTROL:  reg_rdata <= {8'h00, control_r};
				ADDR_IRQ_EN:   reg_rdata <= {8'h00, irq_en_r};
				ADDR_FLAGS:    reg_rdata <= {15'h0000, match_flag_r};
				ADDR_IO_SETUP: reg_rdata <= {8'h00, io_setup_r};
				ADDR_COUNT:    reg_rdata <= count_r;
				ADDR_COMPARE:  reg_rdata <= compare_r;
				ADDR_PORT_DAT: reg_rdata <= {8'h00, port_data_r};
				ADDR_PORT_DIR: reg_rdata <= {8'h00, port_dir_r};
				ADDR_MOTION:   reg_rdata <= {15'h0000, motion_en_r};
				ADDR_ACCEL_N:  reg_rdata <= accel_n_r;
				ADDR_CONST_N:  reg_rdata <= const_n_r;
				ADDR_DECEL_N:  reg_rdata <= decel_n_r;
				ADDR_HOLD_N:   reg_rdata <= hold_n_r;
				ADDR_STATUS:   reg_rdata <= {ramp_idx_r, 3'h0, pat_idx_r, reverse_r, mode_r};
				default:       reg_rdata <= 16'h0000;
			endcase
		end
	end
endmodule : shd_stepper_half_step_drive

// ===== testbench/shd_drive_checker.sv
// Port checker for the half-step drive
`timescale 1ns/1ps
module shd_drive_checker (
	input wire logic        clock,
	input wire logic        reset,
	input wire logic [3:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_write,
	input wire logic        reg_read,
	input wire logic [15:0] reg_rdata,
	input wire logic        phase_a_out,
	input wire logic        phase_b_out,
	input wire logic        phase_a_bar_out,
	input wire logic        phase_b_bar_out,
	input wire logic [3:0]  phase_oe,
	input wire logic        timer_irq
);
	import shd_pkg::*;
	localparam logic [3:0] WHEEL [8] = '{4'h8, 4'hc, 4'h4, 4'h6, 4'h2, 4'h3, 4'h1, 4'h9};
	wire [3:0] ph;
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	// Wheel position of a pattern, 8 when off the wheel
	function automatic logic [3:0] pos(logic [3:0] p);
		pos = 4'h8;
		for (int i = 0; i < 8; i++)
			if (WHEEL[i] == p) pos = 4'(i);
	endfunction : pos
	// Pin pattern, A down to not B
	assign ph = {phase_a_out, phase_b_out, phase_a_bar_out, phase_b_bar_out};
	rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
		else $error("read data outside answer cycle");
	ctrl_width_a: assert property ($past(reg_read) && $past(reg_addr) == ADDR_CONTROL |-> reg_rdata[15:8] == 8'h00)
		else $error("control reads wider than 8 bits");
	legal_pattern_a: assert property (ph == 4'h0 || pos(ph) != 4'h8)
		else $error("phase pins off the wheel");
	step_adjacent_a: assert property ($changed(ph) && ph != 4'h0 && $past(ph) != 4'h0
		|-> 3'(pos(ph) - pos($past(ph))) inside {3'h1, 3'h7})
		else $error("phase pattern skipped a step");
	oe_gate_a: assert property ((ph & ~phase_oe) == 4'h0)
		else $error("phase driven while not output");
	oe_follow_a: assert property (reg_write && reg_addr == ADDR_PORT_DIR |=> ##1 phase_oe == $past(reg_wdata[3:0], 2))
		else $error("enables do not follow direction");
	irq_fall_a: assert property ($fell(timer_irq) |-> $past(reg_write, 2))
		else $error("irq dropped without software write");
	irq_mask_a: assert property (reg_write && reg_addr == ADDR_IRQ_EN && !reg_wdata[0] |=> ##1 !timer_irq)
		else $error("irq raised while disabled");
endmodule : shd_drive_checker

// ===== testbench/shd_motor_model.sv
// Rotor model that follows the phase drive
`timescale 1ns/1ps
module shd_motor_model (
	input  wire logic       clock,
	input  wire logic [3:0] phases,
	output int              position,
	output int              slips
);
	localparam logic [3:0] WHEEL [8] = '{4'h8, 4'hc, 4'h4, 4'h6, 4'h2, 4'h3, 4'h1, 4'h9};
	int was = -1;
	// Rotor angle of a pattern, -1 when off the wheel
	function automatic int ang(logic [3:0] p);
		ang = -1;
		for (int i = 0; i < 8; i++)
			if (WHEEL[i] == p) ang = i;
	endfunction : ang
	initial position = 0;
	initial slips = 0;
	// One step turns the rotor, a jump makes it slip
	always @(posedge clock)
	begin
		int now;
		now = ang(phases);
		if (now >= 0 && was >= 0 && now != was)
		begin
			if ((now - was + 8) % 8 == 1)
				position <= position + 1;
			else if ((now - was + 8) % 8 == 7)
				position <= position - 1;
			else
				slips <= slips + 1;
		end
		if (now >= 0) was <= now;
	end
endmodule : shd_motor_model

// ===== testbench/shd_stepper_half_step_drive_bench.sv
// Self-checking bench for the half-step stepper drive
`timescale 1ns/1ps
module shd_stepper_half_step_drive_bench;
	import shd_pkg::*;
	localparam logic [3:0]  WHEEL [8] = '{4'h8, 4'hc, 4'h4, 4'h6, 4'h2, 4'h3, 4'h1, 4'h9};
	localparam logic [15:0] CMP = 16'h0013;
	// Tick divisors per clock select code; codes 4 to 7 all take the eight-clock external input
	localparam int          DIVS [8] = '{1, 2, 4, 8, 8, 8, 8, 8};
	logic        clock = 1'b0;
	logic        reset = 1'b1;
	logic [3:0]  reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_write = 1'b0;
	logic        reg_read = 1'b0;
	logic [15:0] reg_rdata;
	logic        ext_clock_in = 1'b0;
	logic [2:0]  ext_div = 3'h0;
	wire  [3:0]  ph;
	logic [3:0]  phase_oe;
	logic        timer_irq;
	int          position;
	int          slips;
	int          err_count = 0;
	int          n_checks = 0;
	shd_stepper_half_step_drive u_shd_stepper_half_step_drive (
		.clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .ext_clock_in(ext_clock_in), .phase_a_out(ph[3]),
		.phase_b_out(ph[2]), .phase_a_bar_out(ph[1]), .phase_b_bar_out(ph[0]), .phase_oe(phase_oe),
		.timer_irq(timer_irq));
	shd_motor_model u_shd_motor_model (.clock(clock), .phases(ph), .position(position), .slips(slips));
	// System clock
	always #50 clock = ~clock;
	// External count clock, eight system clocks a period
	always @(posedge clock)
	begin
		ext_div <= ext_div + 3'h1;
		ext_clock_in <= ext_div[2];
	end
	// Hang guard
	initial
	begin
		#2000000;
		err_count++;
		tally_and_finish();
	end
	task automatic tally_and_finish();
		if (err_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : tally_and_finish
	task automatic chk(string w, logic [15:0] e, logic [15:0] g);
		n_checks++;
		if (g !== e)
		begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", w, e, g);
		end
	endtask : chk
	task automatic wr(logic [3:0] a, logic [15:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask : wr
	task automatic rd(logic [3:0] a, output logic [15:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		@(negedge clock);
		d = reg_rdata;
	endtask : rd
	task automatic rdc(string w, logic [3:0] a, logic [15:0] e);
		logic [15:0] d;
		rd(a, d);
		chk(w, e, d);
	endtask : rdc
	task automatic wait_irq(logic lvl, output time t);
		@(negedge clock);
		for (int i = 0; i < 2000 && timer_irq !== lvl; i++)
			@(negedge clock);
		chk("irq level", 16'(lvl), 16'(timer_irq));
		t = $time;
	endtask : wait_irq
	task automatic t_reset();
		chk("pins at reset", 16'h0000, {8'h00, phase_oe, ph});
		rdc("compare", ADDR_COMPARE, COMPARE_RST);
		rdc("count", ADDR_COUNT, 16'h0000);
		rdc("flags", ADDR_FLAGS, 16'h0000);
		rdc("hold", ADDR_HOLD_N, HOLD_RST);
		wr(ADDR_IO_SETUP, 16'h12a5);
		rdc("io setup", ADDR_IO_SETUP, 16'h00a5);
		wr(4'hf, 16'h00ff);
		rdc("unmapped", 4'hf, 16'h0000);
		wr(ADDR_CONTROL, 16'hffff);
		rdc("control", ADDR_CONTROL, 16'h00ff);
	endtask : t_reset
	task automatic t_timer();
		time t1;
		time t2;
		wr(ADDR_IRQ_EN, 16'h0001);
		for (int i = 0; i < 8; i++)
		begin
			wr(ADDR_CONTROL, 16'h0080 | 16'(i << CKS_LSB));
			wr(ADDR_COMPARE, 16'h0007);
			wr(ADDR_COUNT, 16'h0000);
			wr(ADDR_MODE, 16'h0080);
			wait_irq(1'b1, t1);
			wr(ADDR_FLAGS, 16'h0000);
			wait_irq(1'b0, t2);
			wait_irq(1'b1, t2);
			chk("match spacing", 16'(8 * DIVS[i]), 16'((t2 - t1) / 100));
			wr(ADDR_MODE, 16'h0000);
			wr(ADDR_FLAGS, 16'h0000);
		end
	endtask : t_timer
	task automatic t_freeze();
		logic [15:0] d1;
		logic [15:0] d2;
		time         t;
		wr(ADDR_CONTROL, 16'h0000);
		wr(ADDR_COUNT, 16'h0000);
		wr(ADDR_MODE, 16'h0080);
		wait_irq(1'b1, t);
		rd(ADDR_COUNT, d1);
		chk("count runs on", 16'h0001, 16'(d1 > 16'h0007));
		wr(ADDR_IRQ_EN, 16'h0000);
		rdc("flag held", ADDR_FLAGS, 16'h0001);
		chk("irq masked", 16'h0000, 16'(timer_irq));
		wr(ADDR_MODE, 16'h0000);
		rd(ADDR_COUNT, d1);
		repeat (5) @(posedge clock);
		rd(ADDR_COUNT, d2);
		chk("count frozen", d1, d2);
		wr(ADDR_COUNT, 16'h1234);
		rdc("count write", ADDR_COUNT, 16'h1234);
		wr(ADDR_FLAGS, 16'h0001);
		rdc("flag one", ADDR_FLAGS, 16'h0001);
		wr(ADDR_FLAGS, 16'h0000);
		rdc("flag zero", ADDR_FLAGS, 16'h0000);
	endtask : t_freeze
	task automatic t_motion();
		int          ns [4] = '{1, 8, 1, 2};
		shd_mode_t   m = MODE_ACCEL;
		int          cnt = 0;
		logic        dir = 1'b0;
		logic [2:0]  idx = 3'h0;
		logic [15:0] ce;
		logic [15:0] d;
		time         t;
		wr(ADDR_PORT_DIR, 16'h000f);
		wr(ADDR_PORT_DAT, 16'h0008);
		repeat (2) @(negedge clock);
		chk("port pins", 16'h0008, 16'(ph));
		rdc("port dir", ADDR_PORT_DIR, 16'h000f);
		wr(ADDR_CONST_N, 16'h0008);
		rdc("const steps", ADDR_CONST_N, 16'h0008);
		wr(ADDR_ACCEL_N, 16'h0001);
		wr(ADDR_DECEL_N, 16'h0001);
		wr(ADDR_HOLD_N, 16'h0002);
		wr(ADDR_CONTROL, 16'h0080);
		wr(ADDR_COMPARE, CMP);
		wr(ADDR_COUNT, 16'h0000);
		wr(ADDR_IRQ_EN, 16'h0001);
		wr(ADDR_MOTION, 16'h0001);
		rdc("motion on", ADDR_MOTION, 16'h0001);
		wr(ADDR_MODE, 16'h0080);
		// Two half cycles, forward then reverse, each ending in a hold
		for (int k = 0; k < 24; k++)
		begin
			wait_irq(1'b1, t);
			ce = (m == MODE_ACCEL) ? 16'hffff : (m == MODE_DECEL) ? 16'hf000 : CMP;
			if (m != MODE_HOLD)
				idx = idx + (dir ? 3'h7 : 3'h1);
			cnt++;
			if (cnt == ns[m])
			begin
				cnt = 0;
				dir = dir ^ (m == MODE_HOLD);
				m = shd_mode_t'(m + 2'h1);
			end
			rdc("step period", ADDR_COMPARE, ce);
			wr(ADDR_COMPARE, CMP);
			wr(ADDR_FLAGS, 16'h0000);
			chk("pattern", 16'(WHEEL[idx]), 16'(ph));
			rd(ADDR_STATUS, d);
			chk("status", {10'h000, idx, dir, m}, {10'h000, d[5:0]});
			if (k == 11)
				chk("rotor out", 16'h000a, 16'(position));
		end
		chk("rotor back", 16'h0000, 16'(position));
		chk("slips", 16'h0000, 16'(slips));
	endtask : t_motion
	// Main sequence
	initial
	begin
		repeat (10) @(posedge clock);
		reset <= 1'b0;
		t_reset();
		t_timer();
		t_freeze();
		t_motion();
		tally_and_finish();
	end
endmodule : shd_stepper_half_step_drive_bench
bind shd_stepper_half_step_drive shd_drive_checker u_shd_drive_checker (
	.clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
	.reg_read(reg_read), .reg_rdata(reg_rdata), .phase_a_out(phase_a_out), .phase_b_out(phase_b_out),
	.phase_a_bar_out(phase_a_bar_out), .phase_b_bar_out(phase_b_bar_out), .phase_oe(phase_oe),
	.timer_irq(timer_irq));
